// *** logic/bcrs_sequencer.sv ***
// Channel selector, manual range stepper and autorange engine of the bridge
// ----------------------------------------
// Summary of operation
// [R1] Eight-channel counter wraps both ways: 7 up gives 0, 0 down gives 7.
// [R2] Each selector operation moves the channel one step; no direct jumps.
// [R3] Fitted ground option ties a channel's current return only while selected.
// [R4] Relay drivers energise exactly one channel at any time out of reset; all are off while reset is held.
// [R5] Manual up step advances one decade, saturating at 2 megohm.
// [R6] Manual down from 2 ohm gives open; down from open gives 2 megohm.
// [R7] Autorange steps up when result exceeds 19999, unless at 2 megohm.
// [R8] Autorange steps down one decade when result falls below 1800.
// [R9] Automatic down ranging stops at 2 ohm, never selecting open.
// [R10] Automatic changes are separated by a jumper-chosen 1, 4 or 16 s holdoff.
// [R11] Holdoff counts sync clock periods, so faster sync shortens it.
// [R12] With no other jumper fitted the shortest holdoff applies.
// [R13] Autorange uses the converter result regardless of the displayed quantity.
// [R14] Operator should autorange only while plain resistance is displayed.
// [R15] Controller should null the input before switching and release it afterwards.
// [R16] Automatic range changes alter only the range, never excitation.
// [R17] Holdoff restarts on every range change and blocks automatic changes meanwhile.
// [R18] Range code holds seven decades plus open; open after reset.
// ----------------------------------------
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "bcrs_consts.svh"

module bcrs_sequencer #(
  parameter int CHANNELS = 8,
  parameter int SYNC_HZ = `BCRS_SYNC_HZ,
  parameter int HOLD_CNT_W = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`BCRS_ADDR_W-1:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [31:0] busRdata,
  input wire bcrs_pkg::bcrs_step_s panelChan,
  input wire bcrs_pkg::bcrs_step_s panelRange,
  input wire logic panelAuto,
  input wire logic [`BCRS_ADC_W-1:0] adcResult,
  input wire logic adcValid,
  input wire logic syncTick,
  input wire logic [CHANNELS-1:0] channel_ground_jumpers,
  input wire logic holdoff_short_select,
  input wire logic holdoff_mid_select,
  input wire logic holdoff_long_select,
  output logic [CHANNELS-1:0] relayDrive,
  output logic [CHANNELS-1:0] groundTie,
  output bcrs_pkg::bcrs_range_t rangeCode,
  output bcrs_pkg::bcrs_chan_t channelNum,
  output logic autoActive,
  output logic holdoffBusy
);
  import bcrs_pkg::*;

  initial begin
    if (CHANNELS != 8) begin
      $error("bcrs_sequencer: the channel counter serves exactly eight channels");
    end
  end

  // ----------------------------------------
  // Register bus: control, step commands, status, last result
  // ----------------------------------------
  logic autoEnable_reg;
  logic [`BCRS_ADC_W-1:0] lastAdc_reg;
  bcrs_step_s busChan;
  bcrs_step_s busRange;
  logic stepWrite;

  assign stepWrite = busWrite && busAddr == `BCRS_OFF_STEP;
  assign busChan.up = stepWrite && busWdata[`BCRS_STEP_CHAN_UP];
  assign busChan.down = stepWrite && busWdata[`BCRS_STEP_CHAN_DN];
  assign busRange.up = stepWrite && busWdata[`BCRS_STEP_RANGE_UP];
  assign busRange.down = stepWrite && busWdata[`BCRS_STEP_RANGE_DN];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      autoEnable_reg <= `BCRS_RESET_CTRL;
    end else if (busWrite && busAddr == `BCRS_OFF_CTRL) begin
      autoEnable_reg <= busWdata[`BCRS_CTRL_AUTO];
    end
  end

  // Result kept for software; autorange logic reads the live input
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lastAdc_reg <= '0;
    end else if (adcValid) begin
      lastAdc_reg <= adcResult;
    end
  end

  // ----------------------------------------
  // Holdoff selection from the jumpers
  // ----------------------------------------
  bcrs_hold_e holdSel;

  always_comb begin
    if (holdoff_long_select) begin
      holdSel = BCRS_HOLD_LONG;
    end else if (holdoff_mid_select) begin
      holdSel = BCRS_HOLD_MID;
    end else begin
      holdSel = BCRS_HOLD_SHORT; // [R12]
    end
  end

  // ----------------------------------------
  // Channel counter
  // ----------------------------------------
  bcrs_chan_t chan_reg;
  bcrs_chan_t chan_next;
  logic chanUp;
  logic chanDown;

  // Opposite requests in one cycle cancel rather than pick a winner
  assign chanUp = (panelChan.up || busChan.up) && !(panelChan.down || busChan.down);
  assign chanDown = (panelChan.down || busChan.down) && !(panelChan.up || busChan.up);

  always_comb begin
    chan_next = chan_reg;
    if (chanUp) begin
      if (chan_reg == `BCRS_CHAN_LAST) begin
        chan_next = `BCRS_CHAN_FIRST; // [R1]
      end else begin
        chan_next = chan_reg + 3'h1; // [R2]
      end
    end else if (chanDown) begin
      if (chan_reg == `BCRS_CHAN_FIRST) begin
        chan_next = `BCRS_CHAN_LAST; // [R1]
      end else begin
        chan_next = chan_reg - 3'h1; // [R2]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      chan_reg <= `BCRS_CHAN_FIRST;
    end else begin
      chan_reg <= chan_next;
    end
  end

  // ----------------------------------------
  // Relay and ground drivers
  // ----------------------------------------
  // Drivers follow the counter one cycle later; a glitch-free one-hot
  // per bit is worth the extra cycle of relay latency.
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      always_ff @(posedge clk) begin
        if (!nrst) begin
          relayDrive[gi] <= 1'b0;
          groundTie[gi] <= 1'b0;
        end else begin
          relayDrive[gi] <= chan_reg == 3'(gi); // [R4]
          groundTie[gi] <= channel_ground_jumpers[gi] && chan_reg == 3'(gi); // [R3]
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Range stepper and autorange engine
  // ----------------------------------------
  bcrs_range_t range_reg;
  bcrs_range_t range_next;
  logic rangeUp;
  logic rangeDown;
  logic autoOn;
  logic holdBusy;
  logic autoUp;
  logic autoDown;
  logic isDecade;
  logic manualMove;
  logic rangeChange;

  assign rangeUp = (panelRange.up || busRange.up) && !(panelRange.down || busRange.down);
  assign rangeDown = (panelRange.down || busRange.down) && !(panelRange.up || busRange.up);
  assign autoOn = panelAuto || autoEnable_reg;
  assign isDecade = range_reg != `BCRS_RANGE_OPEN;

  // The result is used as is, whatever the display shows
  assign autoUp = autoOn && adcValid && !holdBusy && isDecade // [R13]
    && adcResult > `BCRS_THRESH_UP && range_reg != `BCRS_RANGE_2M; // [R7]
  assign autoDown = autoOn && adcValid && !holdBusy && isDecade // [R17]
    && adcResult < `BCRS_THRESH_DOWN && range_reg != `BCRS_RANGE_2R; // [R8] [R9]

  assign manualMove = rangeUp || rangeDown;

  // Manual steps win over the autorange engine in the same cycle
  always_comb begin
    range_next = range_reg;
    if (rangeUp) begin
      if (range_reg == `BCRS_RANGE_OPEN) begin
        range_next = range_reg;
      end else if (range_reg != `BCRS_RANGE_2M) begin
        range_next = range_reg + 3'h1; // [R5]
      end
    end else if (rangeDown) begin
      if (range_reg == `BCRS_RANGE_2R) begin
        range_next = `BCRS_RANGE_OPEN; // [R6]
      end else if (range_reg == `BCRS_RANGE_OPEN) begin
        range_next = `BCRS_RANGE_2M; // [R6]
      end else begin
        range_next = range_reg - 3'h1;
      end
    end else if (autoUp) begin
      range_next = range_reg + 3'h1; // [R7]
    end else if (autoDown) begin
      range_next = range_reg - 3'h1; // [R8]
    end
  end

  assign rangeChange = range_next != range_reg;

  // Only the range moves here; excitation is not a port of this block
  always_ff @(posedge clk) begin
    if (!nrst) begin
      range_reg <= `BCRS_RESET_RANGE; // [R18]
    end else begin
      range_reg <= range_next; // [R16]
    end
  end

  bcrs_holdoff #(
    .SYNC_HZ(SYNC_HZ),
    .CNT_W(HOLD_CNT_W)
  ) u_holdoff (
    .clk(clk),
    .nrst(nrst),
    .restart(rangeChange), // [R17]
    .syncTick(syncTick), // [R11]
    .holdSel(holdSel), // [R10]
    .busy(holdBusy)
  );

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      autoActive <= 1'b0;
    end else begin
      autoActive <= autoOn;
    end
  end

  assign rangeCode = range_reg;
  assign channelNum = chan_reg;
  assign holdoffBusy = holdBusy;

  // ----------------------------------------
  // Read data, valid in the cycle after the read strobe
  // ----------------------------------------
  logic [31:0] readMux;

  always_comb begin
    readMux = 32'h0000_0000;
    case (busAddr)
      `BCRS_OFF_CTRL: begin
        readMux[`BCRS_CTRL_AUTO] = autoEnable_reg;
      end
      `BCRS_OFF_STATUS: begin
        readMux[`BCRS_ST_CHAN_LSB +: 3] = chan_reg;
        readMux[`BCRS_ST_RANGE_LSB +: 3] = range_reg;
        readMux[`BCRS_ST_AUTO] = autoOn;
        readMux[`BCRS_ST_BUSY] = holdBusy;
        readMux[`BCRS_ST_HSEL_LSB +: 3] = {holdoff_long_select, holdoff_mid_select, holdoff_short_select};
      end
      `BCRS_OFF_ADC: begin
        readMux[`BCRS_ADC_W-1:0] = lastAdc_reg;
      end
      default: begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busRdata <= 32'h0000_0000;
    end else if (busRead) begin
      busRdata <= readMux;
    end else begin
      busRdata <= 32'h0000_0000;
    end
  end

  logic unusedMove;
  assign unusedMove = manualMove;

endmodule

// *** pkg/bcrs_consts.svh ***
// Constants of the bridge channel and range sequencer
`ifndef BCRS_CONSTS_SVH
`define BCRS_CONSTS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define BCRS_ADDR_W 4
`define BCRS_OFF_CTRL 4'h0
`define BCRS_OFF_STEP 4'h4
`define BCRS_OFF_STATUS 4'h8
`define BCRS_OFF_ADC 4'hC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BCRS_CTRL_AUTO 0
`define BCRS_STEP_CHAN_UP 0
`define BCRS_STEP_CHAN_DN 1
`define BCRS_STEP_RANGE_UP 2
`define BCRS_STEP_RANGE_DN 3
`define BCRS_ST_CHAN_LSB 0
`define BCRS_ST_RANGE_LSB 4
`define BCRS_ST_AUTO 8
`define BCRS_ST_BUSY 9
`define BCRS_ST_HSEL_LSB 10

// ----------------------------------------
// Channel and range codes
// ----------------------------------------
`define BCRS_CHAN_FIRST 3'h0
`define BCRS_CHAN_LAST 3'h7
`define BCRS_RANGE_2R 3'h0
`define BCRS_RANGE_2M 3'h6
`define BCRS_RANGE_OPEN 3'h7
`define BCRS_RESET_RANGE 3'h7
`define BCRS_RESET_CTRL 1'h0

// ----------------------------------------
// Autorange thresholds and holdoff timing
// ----------------------------------------
`define BCRS_ADC_W 16
`define BCRS_THRESH_UP 16'h4E1F
`define BCRS_THRESH_DOWN 16'h0708
`define BCRS_SYNC_HZ 50
`define BCRS_HOLD_SHORT_S 1
`define BCRS_HOLD_MID_S 4
`define BCRS_HOLD_LONG_S 16

`endif

// *** pkg/bcrs_pkg.sv ***
// Types shared by the bridge channel and range sequencer
package bcrs_pkg;

  // ----------------------------------------
  // Carriers and encodings
  // ----------------------------------------
  typedef logic [2:0] bcrs_range_t;
  typedef logic [2:0] bcrs_chan_t;

  typedef struct packed {
    logic up;
    logic down;
  } bcrs_step_s;

  typedef enum logic [1:0] {
    BCRS_HOLD_SHORT,
    BCRS_HOLD_MID,
    BCRS_HOLD_LONG
  } bcrs_hold_e;

endpackage

// *** logic/bcrs_holdoff.sv ***
// Holdoff timer between automatic range changes, counted in sync ticks
`timescale 1ns/1ps
`include "bcrs_consts.svh"

module bcrs_holdoff #(
  parameter int SYNC_HZ = `BCRS_SYNC_HZ,
  parameter int SHORT_S = `BCRS_HOLD_SHORT_S,
  parameter int MID_S = `BCRS_HOLD_MID_S,
  parameter int LONG_S = `BCRS_HOLD_LONG_S,
  parameter int CNT_W = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic restart,
  input wire logic syncTick,
  input wire bcrs_pkg::bcrs_hold_e holdSel,
  output logic busy
);
  import bcrs_pkg::*;

  localparam int SHORT_TICKS = SHORT_S * SYNC_HZ;
  localparam int MID_TICKS = MID_S * SYNC_HZ;
  localparam int LONG_TICKS = LONG_S * SYNC_HZ;

  initial begin
    if (SHORT_TICKS < 1 || LONG_TICKS >= (1 << CNT_W) || CNT_W > 31) begin
      $error("bcrs_holdoff: holdoff lengths do not fit the counter");
    end
  end

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] load;

  always_comb begin
    case (holdSel)
      BCRS_HOLD_MID: load = CNT_W'(MID_TICKS);
      BCRS_HOLD_LONG: load = CNT_W'(LONG_TICKS);
      default: load = CNT_W'(SHORT_TICKS);
    endcase
  end

  // Only sync ticks advance the count, so a faster oscillator shortens the wait
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_reg <= '0;
    end else if (restart) begin // [R17]
      count_reg <= load;
    end else if (syncTick && count_reg != '0) begin // [R11]
      count_reg <= count_reg - CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else if (restart) begin
      busy <= 1'b1;
    end else if (syncTick && count_reg <= CNT_W'(1)) begin
      busy <= 1'b0;
    end
  end

endmodule

// *** verification/bcrs_seq_asserts.sv ***
// Checker on the channel, range and holdoff ports of the sequencer
`timescale 1ns/1ps

module bcrs_seq_asserts #(
  parameter int CHANNELS = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic busWrite,
  input wire bcrs_pkg::bcrs_step_s panelChan,
  input wire bcrs_pkg::bcrs_step_s panelRange,
  input wire logic [15:0] adcResult,
  input wire logic adcValid,
  input wire logic [CHANNELS-1:0] channel_ground_jumpers,
  input wire logic [CHANNELS-1:0] relayDrive,
  input wire logic [CHANNELS-1:0] groundTie,
  input wire bcrs_pkg::bcrs_range_t rangeCode,
  input wire bcrs_pkg::bcrs_chan_t channelNum,
  input wire logic autoActive,
  input wire logic holdoffBusy
);
  import bcrs_pkg::*;
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic manQuiet;
  logic autoGo;
  // Manual steps win over autorange, so auto checks need a quiet panel and bus
  assign manQuiet = panelRange == 2'h0 && !busWrite;
  assign autoGo = adcValid && autoActive && !holdoffBusy && manQuiet;
  property p_relay;
    $past(nrst) |-> relayDrive == (CHANNELS'(1) << $past(channelNum));
  endproperty
  a_relay: assert property (p_relay) else $error("relay drive wrong");
  property p_ground;
    $past(nrst) |-> groundTie == (relayDrive & $past(channel_ground_jumpers));
  endproperty
  a_ground: assert property (p_ground) else $error("ground tie wrong");
  property p_chan;
    (panelChan == 2'h2 || panelChan == 2'h1) && !busWrite
      |=> channelNum == $past(channelNum) + ($past(panelChan) == 2'h2 ? 3'h1 : 3'h7);
  endproperty
  a_chan: assert property (p_chan) else $error("channel step wrong");
  property p_rng_up;
    panelRange == 2'h2 && !busWrite
      |=> rangeCode == ($past(rangeCode) < 3'h6 ? $past(rangeCode) + 3'h1 : $past(rangeCode));
  endproperty
  a_rng_up: assert property (p_rng_up) else $error("range up wrong");
  property p_rng_dn;
    panelRange == 2'h1 && !busWrite && rangeCode inside {3'h0, 3'h7}
      |=> rangeCode == ($past(rangeCode) == 3'h0 ? 3'h7 : 3'h6);
  endproperty
  a_rng_dn: assert property (p_rng_dn) else $error("range down wrap wrong");
  property p_auto_up;
    autoGo && adcResult > 16'h4E1F && rangeCode < 3'h6 |=> rangeCode == $past(rangeCode) + 3'h1;
  endproperty
  a_auto_up: assert property (p_auto_up) else $error("auto up missed");
  property p_auto_dn;
    autoGo && adcResult < 16'h0708 && rangeCode != 3'h7
      |=> rangeCode == ($past(rangeCode) == 3'h0 ? 3'h0 : $past(rangeCode) - 3'h1);
  endproperty
  a_auto_dn: assert property (p_auto_dn) else $error("auto down wrong");
  property p_block;
    adcValid && holdoffBusy && manQuiet |=> $stable(rangeCode);
  endproperty
  a_block: assert property (p_block) else $error("range moved in holdoff");
  property p_restart;
    $past(nrst) && rangeCode != $past(rangeCode) |-> holdoffBusy;
  endproperty
  a_restart: assert property (p_restart) else $error("holdoff not restarted");
  c_wrap: cover property (channelNum == 3'h7 && panelChan == 2'h2);
  c_auto: cover property (autoGo && adcResult > 16'h4E1F);
  c_block: cover property (adcValid && holdoffBusy);
endmodule

bind bcrs_sequencer bcrs_seq_asserts #(.CHANNELS(CHANNELS)) bcrs_seq_asserts_inst (.clk, .nrst, .busWrite,
  .panelChan, .panelRange, .adcResult, .adcValid, .channel_ground_jumpers, .relayDrive, .groundTie,
  .rangeCode, .channelNum, .autoActive, .holdoffBusy);

// *** verification/bcrs_relay_mux.sv ***
// Model of the reed relay multiplexer behind the relay drivers
`timescale 1ns/1ps

module bcrs_relay_mux (
  input wire logic [7:0] relayDrive,
  output logic [3:0] closedCount,
  output logic [2:0] sensorSel
);
  // Counts closed relay pairs; more than one would short two sensors together
  always_comb begin
    closedCount = 4'h0;
    sensorSel = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (relayDrive[i]) begin
        closedCount = closedCount + 4'h1;
        sensorSel = 3'(i);
      end
    end
  end
endmodule

// *** verification/bcrs_sequencer_bench.sv ***
// Self-checking bench of the bridge channel and range sequencer
`timescale 1ns/1ps

module bcrs_sequencer_bench;
  import bcrs_pkg::*;
  logic clk, nrst, busWrite, busRead, panelAuto, adcValid, syncTick;
  logic holdoff_short_select, holdoff_mid_select, holdoff_long_select;
  logic [3:0] busAddr, closedCount;
  logic [31:0] busWdata, busRdata, rd;
  bcrs_step_s panelChan, panelRange;
  logic [15:0] adcResult;
  logic [7:0] channel_ground_jumpers, relayDrive, groundTie;
  bcrs_range_t rangeCode;
  bcrs_chan_t channelNum, sensorSel;
  logic autoActive, holdoffBusy;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  // SYNC_HZ of 2 turns the 1, 4 and 16 s holdoffs into 2, 8 and 32 ticks
  bcrs_sequencer #(.SYNC_HZ(2)) bcrs_sequencer_inst (.clk, .nrst, .busAddr, .busWdata, .busWrite, .busRead,
    .busRdata, .panelChan, .panelRange, .panelAuto, .adcResult, .adcValid, .syncTick, .channel_ground_jumpers,
    .holdoff_short_select, .holdoff_mid_select, .holdoff_long_select, .relayDrive, .groundTie, .rangeCode,
    .channelNum, .autoActive, .holdoffBusy);
  bcrs_relay_mux bcrs_relay_mux_inst (.relayDrive, .closedCount, .sensorSel);

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ----------------
  // Shared tasks
  // ----------------
  task automatic print_verdict();
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    busAddr <= a;
    busWdata <= d;
    busWrite <= 1'h1;
    @(posedge clk);
    busWrite <= 1'h0;
  endtask

  task automatic bus_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    busAddr <= a;
    busRead <= 1'h1;
    @(posedge clk);
    busRead <= 1'h0;
    #1 chk(busRdata, e);
  endtask

  task automatic chk_chan(input bcrs_chan_t e);
    chk(channelNum, e);
    chk(relayDrive, 8'h01 << e);
    chk(groundTie, channel_ground_jumpers & (8'h01 << e));
    chk(closedCount, 4'h1);
    chk(sensorSel, e);
  endtask

  task automatic chan_step(input logic u, input logic d, input bcrs_chan_t e);
    @(posedge clk);
    panelChan <= {u, d};
    @(posedge clk);
    panelChan <= 2'h0;
    @(posedge clk);
    #1 chk_chan(e);
  endtask

  task automatic rng_step(input logic u, input logic d, input bcrs_range_t e);
    @(posedge clk);
    panelRange <= {u, d};
    @(posedge clk);
    panelRange <= 2'h0;
    #1 chk(rangeCode, e);
  endtask

  task automatic adc(input logic [15:0] v, input bcrs_range_t e);
    @(posedge clk);
    adcResult <= v;
    adcValid <= 1'h1;
    @(posedge clk);
    adcValid <= 1'h0;
    @(posedge clk);
    #1 chk(rangeCode, e);
  endtask

  // Ticks spaced gap plus two cycles apart; the count must not depend on the spacing
  task automatic hold_len(input int gap, input int e);
    int n;
    n = 0;
    chk(holdoffBusy, 1'h1);
    while (holdoffBusy === 1'h1 && n < 100) begin
      repeat (gap) @(posedge clk);
      syncTick <= 1'h1;
      @(posedge clk);
      syncTick <= 1'h0;
      n++;
      @(posedge clk);
      #1;
    end
    chk(32'(n), 32'(e));
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    nrst = 1'h0;
    {busWrite, busRead, panelAuto, adcValid, syncTick} = 5'h0;
    {busAddr, busWdata, adcResult, panelChan, panelRange} = 56'h0;
    {holdoff_long_select, holdoff_mid_select, holdoff_short_select} = 3'h1;
    channel_ground_jumpers = 8'hA5;
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    repeat (2) @(posedge clk);
    #1 chk(rangeCode, 3'h7);
    chk_chan(3'h0);
    chan_step(1'h0, 1'h1, 3'h7);
    chan_step(1'h1, 1'h0, 3'h0);
    chan_step(1'h1, 1'h1, 3'h0);
    for (int i = 1; i <= 8; i++) begin
      bus_wr(4'h4, 32'h1);
      @(posedge clk);
      #1 chk_chan(3'(i));
    end
    rng_step(1'h1, 1'h0, 3'h7);
    rng_step(1'h0, 1'h1, 3'h6);
    rng_step(1'h1, 1'h0, 3'h6);
    for (int r = 5; r >= 0; r--) begin
      rng_step(1'h0, 1'h1, 3'(r));
    end
    rng_step(1'h0, 1'h1, 3'h7);
    bus_wr(4'h4, 32'h8);
    #1 chk(rangeCode, 3'h6);
    hold_len(3, 2);
    @(posedge clk);
    holdoff_mid_select <= 1'h1;
    rng_step(1'h0, 1'h1, 3'h5);
    hold_len(7, 8);
    @(posedge clk);
    holdoff_long_select <= 1'h1;
    rng_step(1'h0, 1'h1, 3'h4);
    hold_len(2, 32);
    @(posedge clk);
    {holdoff_long_select, holdoff_mid_select} <= 2'h0;
    bus_wr(4'h0, 32'h1);
    bus_rd(4'h0, 32'h1);
    chk(autoActive, 1'h1);
    adc(16'h4E1F, 3'h4);
    adc(16'h4E20, 3'h5);
    adc(16'h0000, 3'h5);
    hold_len(1, 2);
    adc(16'h0708, 3'h5);
    adc(16'h0707, 3'h4);
    hold_len(1, 2);
    adc(16'h4E20, 3'h5);
    hold_len(1, 2);
    adc(16'hFFFF, 3'h6);
    hold_len(1, 2);
    adc(16'hFFFF, 3'h6);
    for (int r = 5; r >= 0; r--) begin
      adc(16'h0000, 3'(r));
      hold_len(1, 2);
    end
    adc(16'h0000, 3'h0);
    bus_rd(4'h8, 32'h500);
    bus_rd(4'hC, 32'h0);
    bus_rd(4'h2, 32'h0);
    bus_rd(4'h4, 32'h0);
    bus_wr(4'h0, 32'h0);
    adc(16'h4E20, 3'h0);
    chk(autoActive, 1'h0);
    // Panel switch alone enables autorange; the next over-range result steps the range from 0 to 1
    @(posedge clk);
    panelAuto <= 1'h1;
    adc(16'h4E20, 3'h1);
    chk(autoActive, 1'h1);
    @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    repeat (2) @(posedge clk);
    #1 chk(rangeCode, 3'h7);
    print_verdict();
  end
endmodule
